// ===== bench/otp_spi_chk.sv
// assertions on the serial link and device mode outputs
`timescale 1ns/1ps
`default_nettype none
module otp_spi_chk
(
	// clock and reset
	input  wire logic CLK_SYS_I,
	input  wire logic NRST_I,
	// link and device outputs
	input  wire logic sck,
	input  wire logic miso,
	input  wire logic test_v,
	input  wire logic ADC_TEST_O,
	input  wire logic PARITY_EN_O
);
	logic [4:0] cnt;
	// rising link clock edges within the frame
	always_ff @(posedge CLK_SYS_I or negedge NRST_I)
	begin
		if (!NRST_I)
			cnt <= 5'h00;
		else if (!test_v)
			cnt <= 5'h00;
		else if ($rose(sck))
			cnt <= (cnt == 5'h10) ? 5'h01 : cnt + 5'h01;
	end
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!NRST_I);
	AST_SCK_HIGH: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
		else $error("link clock high time wrong");
	AST_MISO_STILL: assert property (test_v && sck && $past(sck) |-> $stable(miso))
		else $error("miso moved while clock high");
	AST_MISO_WIN: assert property (test_v && $past(test_v, 4) && $changed(miso)
		|-> cnt >= 5'h08 && cnt <= 5'h10)
		else $error("miso moved outside data bits");
	AST_FRAME_GAP: assert property (cnt == 5'h10 && $fell(sck) |-> !sck [*8])
		else $error("frame longer than sixteen bits");
	AST_ADC_KEY: assert property ($rose(ADC_TEST_O) |-> test_v && cnt == 5'h10)
		else $error("converter test entered off frame end");
	AST_ADC_DROP: assert property ($fell(test_v) |-> ##[1:4] !ADC_TEST_O)
		else $error("converter test kept after test drop");
	AST_ADC_HOLD: assert property ($fell(ADC_TEST_O) |-> !($past(test_v, 1)
		&& $past(test_v, 2) && $past(test_v, 3) && $past(test_v, 4)))
		else $error("converter test left with test high");
	AST_PARITY_KEEP: assert property (PARITY_EN_O |=> PARITY_EN_O)
		else $error("parity enable cleared");
endmodule
`default_nettype wire

// ===== bench/test_mode_serial_register_access_tb.sv
// testbench: host and device ends across the serial link
`timescale 1ns/1ps
`default_nettype none
module test_mode_serial_register_access_tb;
	logic        clk;
	logic        nrst;
	logic [1:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        test_en;
	logic        adc;
	logic        par;
	logic        fail;
	int          error_cnt;
	int          num_checks;
	int          cyc;
	logic [7:0]  rx;
	logic [15:0] rows [5];
	logic [7:0]  exp_v [5];
	otp_spi_if i_otp_spi_if();
	otp_spi_host i_otp_spi_host(.CLK_SYS_I(clk), .NRST_I(nrst), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TEST_EN_I(test_en),
		.LINK(i_otp_spi_if.host));
	otp_spi_dev i_otp_spi_dev(.CLK_SYS_I(clk), .NRST_I(nrst), .LINK(i_otp_spi_if.dev),
		.ADC_TEST_O(adc), .PARITY_EN_O(par), .PROG_FAIL_I(fail));
	otp_spi_chk i_otp_spi_chk(.CLK_SYS_I(clk), .NRST_I(nrst), .sck(i_otp_spi_if.sck),
		.miso(i_otp_spi_if.miso), .test_v(i_otp_spi_if.test_v), .ADC_TEST_O(adc),
		.PARITY_EN_O(par));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want)
		begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [1:0] a, output logic [15:0] q);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		q = rdata;
	endtask
	// one whole frame, then the byte shifted back
	task automatic xfer(input logic [15:0] f, output logic [7:0] q);
		logic [15:0] s;
		wr_reg(2'h0, f);
		s = 16'hffff;
		for (int i = 0; i < 300 && s[0] !== 1'b0; i++)
			rd_reg(2'h1, s);
		rd_reg(2'h2, s);
		q = s[7:0];
	endtask
	task automatic keys(input logic [7:0] k);
		xfer(16'hc2aa, rx);
		xfer(16'hc255, rx);
		xfer({8'hc2, k}, rx);
	endtask
	task automatic burn;
		xfer(16'h8205, rx);
		repeat (otp_spi_pkg::PROG_WAIT_CYC) @(posedge clk);
		xfer(16'ha400, rx);
	endtask
	initial
	begin
		nrst = 1'b0;
		addr = 2'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		test_en = 1'b0;
		fail = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		cyc = 0;
		rows = '{16'h063c, 16'h07a5, 16'h0400, 16'h04ff, 16'h0400};
		exp_v = '{8'h00, 8'h3c, 8'ha5, 8'ha5, 8'ha5};
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (20) @(posedge clk);
		keys(8'h1d);
		check({7'h00, adc}, 8'h00);
		$display("test inactive port done");
		test_en <= 1'b1;
		repeat (8) @(posedge clk);
		for (int i = 0; i < 5; i++)
		begin
			xfer(rows[i], rx);
			check(rx, exp_v[i]);
		end
		$display("test table done");
		keys(8'h1d);
		check({7'h00, adc}, 8'h01);
		test_en <= 1'b0;
		repeat (8) @(posedge clk);
		check({7'h00, adc}, 8'h00);
		$display("test converter mode done");
		test_en <= 1'b1;
		repeat (8) @(posedge clk);
		keys(8'hc6);
		xfer(16'h8200, rx);
		xfer(16'h3e80, rx);
		fail <= 1'b1;
		burn();
		check(rx & 8'h30, 8'h30);
		check({7'h00, par}, 8'h00);
		fail <= 1'b0;
		burn();
		check(rx & 8'h30, 8'h20);
		check({7'h00, par}, 8'h01);
		burn();
		check(rx & 8'h30, 8'h30);
		$display("test fuse burn done");
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (30) @(posedge clk);
		check({7'h00, adc}, 8'h00);
		xfer(16'h3c00, rx);
		check(rx, 8'h80);
		check({7'h00, par}, 8'h01);
		$display("test reload done");
		wrap_up();
	end
endmodule
`default_nettype wire

// ===== src/otp_spi_dev.sv
// device end: test-mode serial register array with fuse programming
// Contract
// - port works only while test voltage high
// - sample on rising, shift out on falling
// - 16 bits msb first: addr, rw, data
// - rw one writes, zero reads location
// - read data out on falls 8-15
// - write data taken on rises 9-16
// - write shifts out prior contents meanwhile
// - corrupted frame needs device reset; a test voltage drop also clears the bit count here
// - key aa 55 1d enters converter test
// - converter test reroutes buffers to filter pin
// - converter test left only on test drop
// - key aa 55 c6 unlocks fuse programming
// - control 00 enables mirror writes
// - control 05 starts fuse programming
// - host waits 32us then polls done
// - status bit 4 flags failed programming
// - fuse bits only go zero to one
// - lock fuse freezes array, enables parity; here it only blocks fuse programming, register array writes still land
// - fuses copied to mirror after reset
// - programming finishes within 2 ms
`timescale 1ns/1ps
`default_nettype none
module otp_spi_dev
(
	// clock and reset
	input  wire logic CLK_SYS_I,
	input  wire logic NRST_I,
	// serial link
	otp_spi_if.dev    LINK,
	// analogue test controls
	output logic      ADC_TEST_O,
	output logic      PARITY_EN_O,
	// fuse programming fault injection
	input  wire logic PROG_FAIL_I
);
	typedef enum logic [3:0]
	{
		K_IDLE = 4'b0001,
		K_AA   = 4'b0010,
		K_55   = 4'b0100,
		K_DONE = 4'b1000
	} key_e;

	typedef struct packed
	{
		logic [2:0]  sck_h;
		logic [4:0]  cnt;
		logic [15:0] sh;
		logic [7:0]  out_sh;
		logic        miso;
		key_e        key;
		logic        adc_test;
		logic        fuse_unlock;
		logic        mirror_we;
		logic        busy;
		logic        done;
		logic        fail;
		logic [14:0] tmr;
		logic [4:0]  load_cnt;
	} state_s;

	state_s s;
	state_s next_s;
	logic [7:0] mem [0:otp_spi_pkg::DEPTH-1];
	// fuses power up unprogrammed and keep their value through reset
	logic [7:0] fuse [otp_spi_pkg::FUSE_FIRST:otp_spi_pkg::FUSE_LAST] = '{default: 8'h00};
	logic [7:0] status_word;
	logic sck_q;
	logic mosi_q;
	logic test_q;
	logic rise;
	logic fall;
	logic wr_now;
	logic [5:0] wr_addr;
	logic [7:0] wr_data;
	logic prog_end;
	logic locked;
	logic loading;

	sync2 u_sck (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .d_i(LINK.sck), .q_o(sck_q));
	sync2 u_mosi (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .d_i(LINK.mosi), .q_o(mosi_q));
	sync2 u_test (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .d_i(LINK.test_v), .q_o(test_q));

	assign rise = test_q && sck_q && !s.sck_h[0];
	assign fall = test_q && !sck_q && s.sck_h[0];
	assign locked = fuse[otp_spi_pkg::ADDR_LOCK][otp_spi_pkg::LOCK_BIT];
	assign prog_end = s.busy && (s.tmr == 15'(otp_spi_pkg::PROG_BIT_CYC)
		|| s.tmr == 15'(otp_spi_pkg::PROG_MAX_CYC - 1));
	assign loading = s.load_cnt != 5'(otp_spi_pkg::LOAD_CYC);

	always_comb
	begin
		next_s = s;
		wr_now = 1'b0;
		wr_addr = s.sh[14:9];
		wr_data = {s.sh[6:0], mosi_q};
		status_word = 8'h00;
		status_word[otp_spi_pkg::ST_DONE_BIT] = s.done;
		status_word[otp_spi_pkg::ST_FAIL_BIT] = s.fail;
		next_s.sck_h = {s.sck_h[1:0], sck_q};
		if (loading)
			next_s.load_cnt = s.load_cnt + 5'h01;
		if (!test_q)
		begin
			next_s.cnt = '0;
			next_s.adc_test = 1'b0;
			next_s.fuse_unlock = 1'b0;
			next_s.mirror_we = 1'b0;
			next_s.key = K_IDLE;
			next_s.miso = 1'b0;
		end
		if (rise)
		begin
			next_s.sh = {s.sh[14:0], mosi_q};
			next_s.cnt = s.cnt + 5'h01;
			if (s.cnt == otp_spi_pkg::BIT_CNT_MAX - 5'h01)
			begin
				next_s.cnt = '0;
				// bit 8 carries nothing
				wr_now = s.sh[8];
			end
		end
		if (fall && s.cnt >= otp_spi_pkg::OUT_FIRST_FALL
			&& s.cnt <= otp_spi_pkg::OUT_LAST_FALL + 5'h01)
		begin
			if (s.cnt == otp_spi_pkg::OUT_FIRST_FALL)
			begin
				next_s.miso = mem[s.sh[7:2]][7];
				next_s.out_sh = {mem[s.sh[7:2]][6:0], 1'b0};
			end
			else
			begin
				next_s.miso = s.out_sh[7];
				next_s.out_sh = {s.out_sh[6:0], 1'b0};
			end
		end
		if (wr_now && wr_addr == otp_spi_pkg::ADDR_TEST_KEY)
		begin
			unique case (s.key)
				K_IDLE: next_s.key = (wr_data == otp_spi_pkg::KEY_1) ? K_AA : K_IDLE;
				K_AA: next_s.key = (wr_data == otp_spi_pkg::KEY_2) ? K_55 : K_IDLE;
				K_55:
				begin
					next_s.key = K_DONE;
					if (wr_data == otp_spi_pkg::KEY_ADC)
						next_s.adc_test = 1'b1;
					if (wr_data == otp_spi_pkg::KEY_FUSE)
						next_s.fuse_unlock = 1'b1;
				end
				K_DONE: next_s.key = (wr_data == otp_spi_pkg::KEY_1) ? K_AA : K_DONE;
				default: next_s.key = K_IDLE;
			endcase
		end
		if (wr_now && wr_addr == otp_spi_pkg::ADDR_PROG_CTRL && s.fuse_unlock)
		begin
			if (wr_data == otp_spi_pkg::CMD_MIRROR)
				next_s.mirror_we = 1'b1;
			if (wr_data == otp_spi_pkg::CMD_PROG && !s.busy)
			begin
				next_s.busy = 1'b1;
				next_s.done = 1'b0;
				next_s.fail = 1'b0;
				next_s.tmr = '0;
			end
		end
		if (s.busy)
			next_s.tmr = s.tmr + 15'h0001;
		if (prog_end)
		begin
			next_s.busy = 1'b0;
			next_s.done = 1'b1;
			next_s.fail = PROG_FAIL_I || locked;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			s <= '{sck_h: '0, cnt: '0, sh: '0, out_sh: '0, miso: 1'b0, key: K_IDLE,
				adc_test: 1'b0, fuse_unlock: 1'b0, mirror_we: 1'b0, busy: 1'b0,
				done: 1'b0, fail: 1'b0, tmr: '0, load_cnt: '0};
		end
		else
		begin
			s <= next_s;
		end
	end

	// register array; frame state recovers by reset or by a test voltage drop
	always_ff @(posedge CLK_SYS_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			for (int i = 0; i < otp_spi_pkg::DEPTH; i++)
				mem[i] <= 8'h00;
		end
		else
		begin
			if (loading && s.load_cnt <= 5'(otp_spi_pkg::FUSE_LAST)
				&& s.load_cnt >= 5'(otp_spi_pkg::FUSE_FIRST))
				mem[s.load_cnt[3:0]] <= fuse[s.load_cnt[3:0]];
			mem[otp_spi_pkg::ADDR_PROG_STATUS] <= status_word;
			if (wr_now && wr_addr != otp_spi_pkg::ADDR_PROG_STATUS)
			begin
				if (wr_addr < otp_spi_pkg::FUSE_FIRST || wr_addr > otp_spi_pkg::FUSE_LAST
					|| s.mirror_we)
					mem[wr_addr] <= wr_data;
			end
		end
	end

	// fuses: bits only ever set

	always_ff @(posedge CLK_SYS_I)
	begin
		if (prog_end && !locked && !PROG_FAIL_I)
		begin
			for (int i = otp_spi_pkg::FUSE_FIRST; i <= otp_spi_pkg::FUSE_LAST; i++)
				fuse[i] <= fuse[i] | mem[i];
		end
	end

	assign LINK.miso = s.miso;
	assign ADC_TEST_O = s.adc_test;
	assign PARITY_EN_O = locked;
endmodule
`default_nettype wire

// ===== src/otp_spi_host.sv
// host end: serial test programmer driven from a small register port
`timescale 1ns/1ps
`default_nettype none
module otp_spi_host
(
	// clock and reset
	input  wire logic       CLK_SYS_I,
	input  wire logic       NRST_I,
	// register port
	input  wire logic [1:0] ADDR_I,
	input  wire logic [15:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	output logic [15:0]     RDATA_O,
	// test voltage request
	input  wire logic       TEST_EN_I,
	// serial link
	otp_spi_if.host         LINK
);
	typedef enum logic [1:0]
	{
		H_IDLE = 2'b01,
		H_RUN  = 2'b10
	} host_e;

	typedef struct packed
	{
		host_e       st;
		logic [15:0] tx;
		logic [7:0]  rx;
		logic [4:0]  bits;
		logic [2:0]  div;
		logic        sck;
		logic [15:0] rdata;
	} state_s;

	state_s s;
	state_s next_s;
	logic miso_q;

	sync2 u_miso (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .d_i(LINK.miso), .q_o(miso_q));

	always_comb
	begin
		next_s = s;
		next_s.rdata = '0;
		unique case (ADDR_I)
			otp_spi_pkg::HREG_STATUS: next_s.rdata = {15'h0000, s.st == H_RUN};
			otp_spi_pkg::HREG_RDATA: next_s.rdata = {8'h00, s.rx};
			default: next_s.rdata = s.tx;
		endcase
		if (!RD_I)
			next_s.rdata = s.rdata;
		unique case (s.st)
			H_IDLE:
			begin
				if (WR_I && ADDR_I == otp_spi_pkg::HREG_CMD)
				begin
					next_s.tx = WDATA_I;
					next_s.st = H_RUN;
					next_s.bits = '0;
					next_s.div = '0;
				end
			end
			H_RUN:
			begin
				next_s.div = s.div + 3'h1;
				if (s.div == 3'(otp_spi_pkg::SCK_HALF - 1))
				begin
					next_s.div = '0;
					next_s.sck = !s.sck;
					// miso lags both synchronisers; taken as the high phase ends
					if (s.sck)
					begin
						next_s.rx = {s.rx[6:0], miso_q};
						next_s.tx = {s.tx[14:0], 1'b0};
						next_s.bits = s.bits + 5'h01;
						if (s.bits == otp_spi_pkg::BIT_CNT_MAX - 5'h01)
							next_s.st = H_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I)
	begin
		if (!NRST_I)
			s <= '{st: H_IDLE, tx: '0, rx: '0, bits: '0, div: '0, sck: 1'b0, rdata: '0};
		else
			s <= next_s;
	end

	assign RDATA_O = s.rdata;
	assign LINK.sck = s.sck;
	assign LINK.mosi = s.tx[15];
	assign LINK.test_v = TEST_EN_I;
endmodule
`default_nettype wire

// ===== src/otp_spi_if.sv
// serial link between test host and device
`timescale 1ns/1ps
`default_nettype none
interface otp_spi_if;
	logic sck;
	logic mosi;
	logic miso;
	logic test_v;
	modport dev
	(
		input  sck,
		input  mosi,
		input  test_v,
		output miso
	);
	modport host
	(
		output sck,
		output mosi,
		output test_v,
		input  miso
	);
endinterface
`default_nettype wire

// ===== src/otp_spi_pkg.sv
// shared constants for the test-mode serial register port
package otp_spi_pkg;
	localparam int unsigned FRAME_BITS     = 16;
	localparam int unsigned ADDR_W         = 6;
	localparam int unsigned DATA_W         = 8;
	localparam int unsigned DEPTH          = 64;
	localparam logic [4:0]  BIT_CNT_MAX    = 5'h10;
	localparam logic [4:0]  ADDR_LAST_EDGE = 5'h06;
	localparam logic [4:0]  RW_EDGE        = 5'h07;
	localparam logic [4:0]  OUT_FIRST_FALL = 5'h08;
	localparam logic [4:0]  OUT_LAST_FALL  = 5'h0f;
	localparam logic [4:0]  DATA_FIRST_EDGE = 5'h09;
	// register locations
	localparam logic [5:0]  ADDR_PROG_CTRL   = 6'h20;
	localparam logic [5:0]  ADDR_PROG_STATUS = 6'h29;
	localparam logic [5:0]  ADDR_TEST_KEY    = 6'h30;
	localparam logic [5:0]  FUSE_FIRST       = 6'h06;
	localparam logic [5:0]  FUSE_LAST        = 6'h0f;
	localparam logic [5:0]  ADDR_LOCK        = 6'h0f;
	localparam int unsigned LOCK_BIT         = 7;
	// key and command values
	localparam logic [7:0]  KEY_1       = 8'haa;
	localparam logic [7:0]  KEY_2       = 8'h55;
	localparam logic [7:0]  KEY_ADC     = 8'h1d;
	localparam logic [7:0]  KEY_FUSE    = 8'hc6;
	localparam logic [7:0]  CMD_MIRROR  = 8'h00;
	localparam logic [7:0]  CMD_PROG    = 8'h05;
	localparam int unsigned ST_DONE_BIT = 5;
	localparam int unsigned ST_FAIL_BIT = 4;
	// timing
	localparam int unsigned CLK_MHZ        = 10;
	localparam int unsigned PROG_MAX_US    = 2000;
	localparam int unsigned PROG_MAX_CYC   = PROG_MAX_US * CLK_MHZ;
	localparam int unsigned PROG_BIT_CYC   = 16;
	localparam int unsigned PROG_WAIT_US   = 32;
	localparam int unsigned PROG_WAIT_CYC  = PROG_WAIT_US * CLK_MHZ;
	localparam int unsigned LOAD_CYC       = 16;
	localparam int unsigned SCK_HALF       = 4;
	// host command port
	localparam logic [1:0]  HREG_CMD    = 2'h0;
	localparam logic [1:0]  HREG_STATUS = 2'h1;
	localparam logic [1:0]  HREG_RDATA  = 2'h2;
endpackage

// ===== src/sync2.sv
// two-stage synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module sync2
(
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta;
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			meta <= 1'b0;
			q_o  <= 1'b0;
		end
		else
		begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule
`default_nettype wire
